// File: core/dmx_pkg.sv
package dmx_pkg;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_PERIOD_NS  = 40;
  localparam int INSTR_CYCLE_NS = 160;
  localparam int PHASE_COUNT    = INSTR_CYCLE_NS / CLK_PERIOD_NS;

  // ********************************
  // instruction encodings
  // ********************************
  localparam logic [9:0]  OP_LOAD_PTR    = 10'h3B8;
  localparam logic [7:0]  OP_LOAD_PTR_LO = 8'hF0;
  localparam logic [5:0]  OP_MOVE_REG    = 6'h14;
  localparam logic [3:0]  OP_REG_TO_REG  = 4'hC;
  localparam logic [3:0]  OP_SECOND_WORD = 4'hF;
  localparam logic [7:0]  OP_SET_BANK    = 8'h01;
  localparam logic [1:0]  PTR_SEL_MAX    = 2'h2;
  localparam int          PTR_COUNT      = 3;
  localparam int          BIT_DEST       = 9;
  localparam int          BIT_BANKED     = 8;
  localparam int          BIT_ACC_UPPER  = 7;

  // ********************************
  // data space
  // ********************************
  localparam int          ADDR_W         = 12;
  localparam int          DEPTH          = 4096;
  localparam logic [11:0] W_ADDR         = 12'hFE8;
  localparam logic [3:0]  ACC_LO_BANK    = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK    = 4'hF;

  // ********************************
  // register port map and reset values
  // ********************************
  localparam logic [3:0]  REG_W          = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h1;
  localparam logic [3:0]  REG_BANK       = 4'h2;
  localparam logic [3:0]  REG_PTR_BASE   = 4'h4;
  localparam int          STAT_N_BIT     = 4;
  localparam int          STAT_Z_BIT     = 2;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  W_RESET        = 8'h00;
  localparam logic [3:0]  BANK_RESET     = 4'h0;
  localparam logic [7:0]  PTR_RESET      = 8'h00;

  typedef enum logic [2:0] {
    ST_FETCH    = 3'b001,
    ST_PTR_LO   = 3'b010,
    ST_MOVE_DST = 3'b100
  } dmx_state_type;
endpackage

// File: core/dmx_phase.sv
module dmx_phase (
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  output logic      [dmx_pkg::PHASE_COUNT-1:0] o_phase
);
  logic [dmx_pkg::PHASE_COUNT-1:0] next_phase;

  // one-hot rotation: bit 0 is the decode quarter
  always_comb begin
    next_phase = {o_phase[dmx_pkg::PHASE_COUNT-2:0], o_phase[dmx_pkg::PHASE_COUNT-1]};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_phase <= {{(dmx_pkg::PHASE_COUNT-1){1'b0}}, 1'b1};
    end else begin
      o_phase <= next_phase;
    end
  end
endmodule

// File: core/dmx_dmem.sv
module dmx_dmem (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_re,
  input  wire logic [dmx_pkg::ADDR_W-1:0]  i_raddr,
  output logic      [7:0]                  o_rdata,
  input  wire logic                        i_we,
  input  wire logic [dmx_pkg::ADDR_W-1:0]  i_waddr,
  input  wire logic [7:0]                  i_wdata
);
  logic [7:0] mem [dmx_pkg::DEPTH];
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = o_rdata;
    if (i_re) begin
      next_rdata = mem[i_raddr];
    end
  end

  // array left without reset, as a real ram would be
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end
endmodule

// File: core/dmx_exec.sv
// Notes on behaviour
// - load pointer writes 12-bit literal into selected pointer
// - load pointer is two words, 1111 0000 second
// - two cycles, high then low byte, no flags
// - move register: d=0 to W, d=1 back
// - a=0 access bank, a=1 bank select page
// - one cycle move, updates negative and zero
// - reg-to-reg copies any 12-bit source to destination
// - reg-to-reg words prefixed 1100 then 1111
// - reg-to-reg: read first cycle, write second last phase
// - W usable as reg-to-reg source or destination
// - set bank writes literal low nibble, no flags
//
// The strobed register port and the register offsets were left to the implementer.
module dmx_exec (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_valid,
  output logic             o_instr_take,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata
);
  // ********************************
  // quarter phases and data memory
  // ********************************
  logic [dmx_pkg::PHASE_COUNT-1:0] phase;
  logic                            q1;
  logic                            q2;
  logic                            q3;
  logic                            q4;
  logic                            mem_re;
  logic [11:0]                     mem_raddr;
  logic [7:0]                      mem_rdata;
  logic                            mem_we;
  logic [11:0]                     mem_waddr;
  logic [7:0]                      mem_wdata;

  dmx_phase dmx_phase_i (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .o_phase (phase)
  );

  assign q1 = phase[0];
  assign q2 = phase[1];
  assign q3 = phase[2];
  assign q4 = phase[3];

  dmx_dmem dmx_dmem_i (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_re    (mem_re),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata)
  );

  // ********************************
  // state
  // ********************************
  dmx_pkg::dmx_state_type state;
  dmx_pkg::dmx_state_type next_state;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic        ir_ok;
  logic        next_ir_ok;
  logic [7:0]  w;
  logic [7:0]  next_w;
  logic [7:0]  status;
  logic [7:0]  next_status;
  logic [3:0]  bank;
  logic [3:0]  next_bank;
  logic [7:0]  src_data;
  logic [7:0]  next_src_data;
  logic [1:0]  pend_sel;
  logic [1:0]  next_pend_sel;
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  logic [3:0]  ptr_hi [dmx_pkg::PTR_COUNT];
  logic [7:0]  ptr_lo [dmx_pkg::PTR_COUNT];

  // ********************************
  // decode
  // ********************************
  logic        fetch;
  logic        do_ptr_hi;
  logic        do_ptr_lo;
  logic        do_move;
  logic        do_copy_src;
  logic        do_copy_dst;
  logic        do_bank;
  logic        stray;
  logic [11:0] move_addr;
  logic [11:0] src_addr;
  logic [11:0] dst_addr;
  logic        dst_write;

  assign fetch = (state == dmx_pkg::ST_FETCH);
  assign do_ptr_hi = ir_ok && fetch && ir[15:6] == dmx_pkg::OP_LOAD_PTR
                     && ir[5:4] <= dmx_pkg::PTR_SEL_MAX;
  assign do_ptr_lo = ir_ok && state == dmx_pkg::ST_PTR_LO
                     && ir[15:8] == dmx_pkg::OP_LOAD_PTR_LO;
  assign do_move = ir_ok && fetch && ir[15:10] == dmx_pkg::OP_MOVE_REG;
  assign do_copy_src = ir_ok && fetch && ir[15:12] == dmx_pkg::OP_REG_TO_REG;
  assign do_copy_dst = ir_ok && state == dmx_pkg::ST_MOVE_DST
                       && ir[15:12] == dmx_pkg::OP_SECOND_WORD;
  assign do_bank = ir_ok && fetch && ir[15:8] == dmx_pkg::OP_SET_BANK;
  // operand word reaching decode directly matches nothing and so does nothing
  assign stray = ir_ok && fetch && ir[15:12] == dmx_pkg::OP_SECOND_WORD;

  // banked or access addressing for the single-word move
  always_comb begin
    if (ir[dmx_pkg::BIT_BANKED]) begin
      move_addr = {bank, ir[7:0]};
    end else if (ir[dmx_pkg::BIT_ACC_UPPER]) begin
      move_addr = {dmx_pkg::ACC_HI_BANK, ir[7:0]};
    end else begin
      move_addr = {dmx_pkg::ACC_LO_BANK, ir[7:0]};
    end
  end

  assign src_addr  = do_copy_src ? ir[11:0] : move_addr;
  assign dst_addr  = do_copy_dst ? ir[11:0] : move_addr;
  assign dst_write = (do_move && ir[dmx_pkg::BIT_DEST]) || do_copy_dst;

  // W lives outside the ram, so reads and writes of its address divert
  assign mem_re    = q2 && (do_move || do_copy_src) && src_addr != dmx_pkg::W_ADDR;
  assign mem_raddr = src_addr;
  assign mem_we    = q4 && dst_write && dst_addr != dmx_pkg::W_ADDR;
  assign mem_waddr = dst_addr;
  assign mem_wdata = src_data;

  assign o_instr_take = q1 && i_instr_valid;
  assign o_rdata      = rdata;

  // ********************************
  // sequencing and core registers
  // ********************************
  always_comb begin
    next_state    = state;
    next_ir       = ir;
    next_ir_ok    = ir_ok;
    next_w        = w;
    next_status   = status;
    next_bank     = bank;
    next_src_data = src_data;
    next_pend_sel = pend_sel;
    if (i_wr && i_addr == dmx_pkg::REG_W) begin
      next_w = i_wdata;
    end
    if (i_wr && i_addr == dmx_pkg::REG_STATUS) begin
      next_status = i_wdata;
    end
    if (i_wr && i_addr == dmx_pkg::REG_BANK) begin
      next_bank = i_wdata[3:0];
    end
    if (q1) begin
      next_ir_ok = i_instr_valid;
      if (i_instr_valid) begin
        next_ir = i_instr;
      end
    end
    if (q3 && (do_move || do_copy_src)) begin
      next_src_data = (src_addr == dmx_pkg::W_ADDR) ? w : mem_rdata;
    end
    if (q4) begin
      // the core wins over a register-port write in the same cycle
      if (do_move) begin
        if (!ir[dmx_pkg::BIT_DEST] || move_addr == dmx_pkg::W_ADDR) begin
          next_w = src_data;
        end
        next_status[dmx_pkg::STAT_N_BIT] = src_data[7];
        next_status[dmx_pkg::STAT_Z_BIT] = (src_data == 8'h00);
      end
      if (do_copy_dst && dst_addr == dmx_pkg::W_ADDR) begin
        next_w = src_data;
      end
      if (do_bank) begin
        next_bank = ir[3:0];
      end
      if (do_ptr_hi) begin
        next_pend_sel = ir[5:4];
      end
      case (state)
        dmx_pkg::ST_FETCH: begin
          if (do_ptr_hi) begin
            next_state = dmx_pkg::ST_PTR_LO;
          end else if (do_copy_src) begin
            next_state = dmx_pkg::ST_MOVE_DST;
          end
        end
        dmx_pkg::ST_PTR_LO,
        dmx_pkg::ST_MOVE_DST: begin
          // a missing operand word stretches the instruction by a cycle
          if (ir_ok) begin
            next_state = dmx_pkg::ST_FETCH;
          end
        end
        default: begin
          next_state = dmx_pkg::ST_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state    <= dmx_pkg::ST_FETCH;
      ir       <= 16'h0000;
      ir_ok    <= 1'b0;
      w        <= dmx_pkg::W_RESET;
      status   <= dmx_pkg::STATUS_RESET;
      bank     <= dmx_pkg::BANK_RESET;
      src_data <= 8'h00;
      pend_sel <= 2'h0;
    end else begin
      state    <= next_state;
      ir       <= next_ir;
      ir_ok    <= next_ir_ok;
      w        <= next_w;
      status   <= next_status;
      bank     <= next_bank;
      src_data <= next_src_data;
      pend_sel <= next_pend_sel;
    end
  end

  // ********************************
  // indirect pointers
  // ********************************
  for (genvar n = 0; n < dmx_pkg::PTR_COUNT; n++) begin : g_ptr
    localparam logic [3:0] HI_ADDR = 4'(dmx_pkg::REG_PTR_BASE + 2 * n);
    localparam logic [3:0] LO_ADDR = 4'(dmx_pkg::REG_PTR_BASE + 2 * n + 1);
    logic [3:0] next_hi;
    logic [7:0] next_lo;

    always_comb begin
      next_hi = ptr_hi[n];
      next_lo = ptr_lo[n];
      if (i_wr && i_addr == HI_ADDR) begin
        next_hi = i_wdata[3:0];
      end
      if (i_wr && i_addr == LO_ADDR) begin
        next_lo = i_wdata;
      end
      if (q4 && do_ptr_hi && ir[5:4] == 2'(n)) begin
        next_hi = ir[3:0];
      end
      if (q4 && do_ptr_lo && pend_sel == 2'(n)) begin
        next_lo = ir[7:0];
      end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        ptr_hi[n] <= dmx_pkg::PTR_RESET[3:0];
        ptr_lo[n] <= dmx_pkg::PTR_RESET;
      end else begin
        ptr_hi[n] <= next_hi;
        ptr_lo[n] <= next_lo;
      end
    end
  end

  // ********************************
  // register port read
  // ********************************
  always_comb begin
    next_rdata = rdata;
    if (i_rd) begin
      next_rdata = 8'h00;
      case (i_addr)
        dmx_pkg::REG_W:      next_rdata = w;
        dmx_pkg::REG_STATUS: next_rdata = status;
        dmx_pkg::REG_BANK:   next_rdata = {4'h0, bank};
        default: begin
          for (int k = 0; k < dmx_pkg::PTR_COUNT; k++) begin
            if (i_addr == 4'(dmx_pkg::REG_PTR_BASE + 2 * k)) begin
              next_rdata = {4'h0, ptr_hi[k]};
            end
            if (i_addr == 4'(dmx_pkg::REG_PTR_BASE + 2 * k + 1)) begin
              next_rdata = ptr_lo[k];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_ptr_first;
    q4 && do_ptr_hi;
  endsequence

  sequence s_copy_first;
    q4 && do_copy_src;
  endsequence

  sequence s_copy_second_read;
    q2 && state == dmx_pkg::ST_MOVE_DST;
  endsequence

  chk_ptr_high_byte: assert property (
    s_ptr_first |=> ptr_hi[pend_sel] == $past(ir[3:0]))
    else $error("pointer high byte not loaded");
  chk_ptr_low_byte: assert property (
    q4 && do_ptr_lo |=> ptr_lo[$past(pend_sel)] == $past(ir[7:0]))
    else $error("pointer low byte not loaded");
  chk_ptr_two_word: assert property (
    s_ptr_first |=> state == dmx_pkg::ST_PTR_LO ##3 (q4 && state == dmx_pkg::ST_PTR_LO))
    else $error("load pointer did not wait for its second word");
  chk_no_flag_change: assert property (
    q4 && (do_ptr_hi || do_ptr_lo || do_bank) |=> $stable(status))
    else $error("status changed by a flag-free instruction");
  chk_move_to_w: assert property (
    q4 && do_move && !ir[dmx_pkg::BIT_DEST] |=> w == $past(src_data))
    else $error("move did not reach W");
  chk_move_flags: assert property (
    q4 && do_move |=> status[dmx_pkg::STAT_Z_BIT] == ($past(src_data) == 8'h00)
    && status[dmx_pkg::STAT_N_BIT] == $past(src_data[7]))
    else $error("move flags wrong");
  chk_bank_addr: assert property (
    q2 && do_move && ir[dmx_pkg::BIT_BANKED] |-> mem_raddr == {bank, ir[7:0]})
    else $error("banked address wrong");
  chk_copy_source: assert property (
    q2 && do_copy_src && ir[11:0] != dmx_pkg::W_ADDR |-> mem_re && mem_raddr == ir[11:0])
    else $error("copy source not read");
  chk_copy_no_read: assert property (
    s_copy_first ##2 s_copy_second_read |-> !mem_re)
    else $error("read during copy second cycle");
  chk_copy_dest: assert property (
    q4 && do_copy_dst && ir[11:0] != dmx_pkg::W_ADDR
    |-> mem_we && mem_waddr == ir[11:0] && mem_wdata == src_data)
    else $error("copy destination not written");
  chk_set_bank: assert property (
    q4 && do_bank |=> bank == $past(ir[3:0]))
    else $error("bank select not loaded");
  chk_stray_nop: assert property (
    q4 && stray |-> !mem_we ##1 ($stable(w) && $stable(status) && state == dmx_pkg::ST_FETCH))
    else $error("stray operand word changed state");
endmodule

// File: bench/dmx_prog_model.sv
module dmx_prog_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_take,
  output logic      [15:0] o_instr,
  output logic             o_valid,
  output logic             o_empty
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // word store, bit 16 low marks an idle slot
  // ****************************************
  logic [16:0] prog [128];
  int          n = 0;
  int          idx;
  int          idle;
  logic [15:0] last;

  task automatic push(input logic [16:0] w);
    prog[n] = w;
    n = n + 1;
  endtask

  // an idle slot between two words holds the operand back
  assign o_valid = (idx < n) && (idle == 0) && prog[idx][16];
  assign o_empty = (idx >= n);
  // no stale word on the bus while nothing is offered
  assign o_instr = o_valid ? prog[idx][15:0] : ~last;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idx <= 0;
      idle <= 0;
      last <= 16'h0000;
    end else if (idle > 0) begin
      idle <= idle - 1;
      if (idle == 1) begin
        idx <= idx + 1;
      end
    end else if (idx < n && !prog[idx][16]) begin
      idle <= 4;
    end else if (i_take && o_valid) begin
      last <= prog[idx][15:0];
      idx <= idx + 1;
    end
  end
endmodule

// File: bench/dmx_exec_tb.sv
module dmx_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  o_rdata;
  logic [15:0] instr;
  logic        instr_valid;
  logic        instr_take;
  int          bad_count = 0;
  int          tests_run = 0;

  always #20 i_clk = ~i_clk;

  dmx_exec dmx_exec_i (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_instr      (instr),
    .i_instr_valid(instr_valid),
    .o_instr_take (instr_take),
    .i_addr       (i_addr),
    .i_wdata      (i_wdata),
    .i_wr         (i_wr),
    .i_rd         (i_rd),
    .o_rdata      (o_rdata)
  );

  dmx_prog_model dmx_prog_model_i (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_take (instr_take),
    .o_instr(instr),
    .o_valid(instr_valid),
    .o_empty()
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    tests_run++;
    if (o_rdata !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t reg %h got %h exp %h", $time, a, o_rdata, exp);
    end
  endtask

  // pushed off the edge so model and core see the same valid at the edge
  task automatic ins(input logic [15:0] w);
    #1;
    dmx_prog_model_i.push({1'b1, w});
  endtask

  task automatic gap();
    #1;
    dmx_prog_model_i.push(17'h00000);
  endtask

  // wait until every word is taken, then two more instruction cycles
  task automatic run();
    int k;
    k = 0;
    @(posedge i_clk);
    while (dmx_prog_model_i.o_empty !== 1'b1 && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 400) begin
      bad_count++;
      $display("[FAIL] t=%0t run got %h exp %h", $time, k, 400);
    end
    repeat (8) @(posedge i_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    for (int a = 0; a < 10; a++) begin
      expect_reg(4'(a), 8'h00);
    end
    $display("test reset done");
  endtask

  task automatic t_load_ptr();
    ins(16'hEE23);
    ins(16'hF0AB);
    ins(16'hEE0F);
    ins(16'hF0FF);
    ins(16'hEE3C);
    ins(16'hF055);
    ins(16'hEE11);
    gap();
    ins(16'hF022);
    run();
    expect_reg(4'h8, 8'h03);
    expect_reg(4'h9, 8'hAB);
    expect_reg(4'h4, 8'h0F);
    expect_reg(4'h5, 8'hFF);
    expect_reg(4'h6, 8'h01);
    expect_reg(4'h7, 8'h22);
    expect_reg(4'h1, 8'h00);
    $display("test load pointer done");
  endtask

  task automatic t_set_bank();
    ins(16'h01F5);
    run();
    expect_reg(4'h2, 8'h05);
    expect_reg(4'h1, 8'h00);
    $display("test set bank done");
  endtask

  // destinations stay clear of counter and return-stack bytes
  task automatic t_reg_move();
    reg_wr(4'h0, 8'h33);
    ins(16'hCFE8);
    gap();
    ins(16'hF123);
    ins(16'hCFE8);
    ins(16'hF000);
    run();
    reg_wr(4'h0, 8'h00);
    ins(16'hC123);
    ins(16'hFFE8);
    run();
    expect_reg(4'h0, 8'h33);
    reg_wr(4'h0, 8'h00);
    ins(16'hC000);
    ins(16'hFFE8);
    run();
    expect_reg(4'h0, 8'h33);
    $display("test reg to reg done");
  endtask

  task automatic t_move_reg();
    ins(16'h0101);
    ins(16'h5123);
    run();
    expect_reg(4'h0, 8'h33);
    expect_reg(4'h1, 8'h00);
    reg_wr(4'h0, 8'h80);
    ins(16'hCFE8);
    ins(16'hF012);
    run();
    reg_wr(4'h0, 8'h00);
    ins(16'h5012);
    run();
    expect_reg(4'h0, 8'h80);
    expect_reg(4'h1, 8'h10);
    reg_wr(4'h0, 8'h00);
    ins(16'h52E8);
    run();
    expect_reg(4'h0, 8'h00);
    expect_reg(4'h1, 8'h04);
    $display("test move register done");
  endtask

  task automatic t_stray();
    reg_wr(4'h0, 8'h11);
    ins(16'hCFE8);
    ins(16'hF07F);
    run();
    reg_wr(4'h0, 8'h5A);
    // a stray word aimed at W would copy the held 11 over 5A
    ins(16'hFFE8);
    run();
    expect_reg(4'h0, 8'h5A);
    expect_reg(4'h7, 8'h22);
    expect_reg(4'h1, 8'h04);
    ins(16'h507F);
    run();
    expect_reg(4'h0, 8'h11);
    $display("test stray operand done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_load_ptr();
    t_set_bank();
    t_reg_move();
    t_move_reg();
    t_stray();
    give_verdict();
  end

  // generous against roughly three hundred cycles of tests
  initial begin
    #(40 * 20000);
    bad_count++;
    give_verdict();
  end
endmodule
